// [verilog/sps_map.svh]
// constants for the start-up and protection sequencer
// assumes a 100 MHz clock and comparator flags already at logic level
// Overview of operation
// R1 - low charge below trip, high above
// R2 - low charge between lockout and start-up
// R3 - start-up level enables core, stops charging
// R4 - first enable protect source, soft-starts, clamp
// R5 - power-factor runs when three enable flags
// R6 - flyback runs once its soft-start charged
// R7 - protect input late: source off, recharge
// R8 - flyback control time-out forces safe restart
// R9 - protection stops both, supply decays
// R10 - latched: recharge supply, never restart
// R11 - safe restart: recharge then full sequence
// R12 - output overvoltage halts power-factor only
// R13 - mains undervoltage halts power-factor, hysteresis restart
// R14 - supply lockout: stop, safe restart, recharge
// R15 - power down: all off until mains
// R16 - protect input low latches both off
// R17 - switching inhibited until protect input enabled
// R18 - protect input acted upon without filtering
// R19 - latched disables mains-sense clamp
// R20 - mains below 750 then 870 clears latch
// R21 - full supply loss clears latch
// R22 - over-temperature latches, no recharge
// R23 - comparator flags pass two-stage synchroniser
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// number of comparator flags
`define SPS_NFLAG 16
// flag bit positions in the synchroniser vector
`define SPS_F_TRIP 0
`define SPS_F_SUPPLY_UNDERVOLTAGE_LOCKOUT 1
`define SPS_F_START 2
`define SPS_F_PROT_EN 3
`define SPS_F_PROT_TRIP 4
`define SPS_F_COMP_EN 5
`define SPS_F_SS_PFC 6
`define SPS_F_SS_FLY 7
`define SPS_F_FLY_TO 8
`define SPS_F_OVP 9
`define SPS_F_MAINS_STOP 10
`define SPS_F_MAINS_START 11
`define SPS_F_PDOWN 12
`define SPS_F_FLR_LOW 13
`define SPS_F_FLR_HIGH 14
`define SPS_F_OTP 15
// charge current codes
`define SPS_CHG_OFF 2'h0
`define SPS_CHG_LOW 2'h1
`define SPS_CHG_HIGH 2'h2
`endif

// [verilog/sps_pkg.sv]
// types for the start-up and protection sequencer
// assumes sps_map.svh constants are used beside it
package sps_pkg;
    // main sequencer states
    typedef enum logic [2:0] {
        SPS_CHARGE,
        SPS_STARTUP,
        SPS_RUN,
        SPS_DECAY,
        SPS_PDOWN
    } sps_state_t;
endpackage

// [verilog/sps_sync_if.sv]
// carrier between the sequencer and its flag synchroniser
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
interface sps_sync_if;
    // raw and synchronised comparator flags
    logic [`SPS_NFLAG-1:0] raw;
    logic [`SPS_NFLAG-1:0] flag;
    modport sync (input raw, output flag);
    modport user (output raw, input flag);
endinterface
`default_nettype wire

// [verilog/sps_sync.sv]
// two-stage synchroniser for the comparator flags
// assumes flags are asynchronous levels from analog comparators
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module sps_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // flags
    sps_sync_if.sync s
);
    // first stage, read only by the second
    logic [`SPS_NFLAG-1:0] meta;
    logic [`SPS_NFLAG-1:0] stage2;
    // ************************************************
    // synchroniser stages
    // ************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= '0;
            stage2 <= '0;
        end
        else
        begin
            meta <= s.raw; // R23
            stage2 <= meta; // R23
        end
    end
    assign s.flag = stage2;
endmodule // sps_sync
`default_nettype wire

// [verilog/sps_top.sv]
// supervisory sequencer for start-up, lockout and protection
// assumes comparator flags as levels and a power-on reset on nrst
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module sps_top
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // supply comparators
    input wire logic supply_above_trip,
    input wire logic supply_above_lockout,
    input wire logic supply_above_startup,
    // protection input comparators
    input wire logic protect_above_enable,
    input wire logic protect_below_trip,
    // soft-start and compensation comparators
    input wire logic compensation_enable_level,
    input wire logic pfc_softstart_charged,
    input wire logic flyback_softstart_charged,
    // flyback control time-out
    input wire logic flyback_timeout_level,
    // power-factor output and mains comparators
    input wire logic overvoltage_protect,
    input wire logic mains_below_stop_level,
    input wire logic mains_above_start_level,
    input wire logic mains_below_power_down_level,
    input wire logic mains_below_reset_low,
    input wire logic mains_above_reset_high,
    // over-temperature comparator
    input wire logic over_temperature,
    // charge current level
    output logic [1:0] charge_level,
    // converter enables
    output logic pfc_drive_en,
    output logic flyback_drive_en,
    // current sources, clamps and core enable
    output logic protect_source_en,
    output logic softstart_en,
    output logic compensation_clamp_en,
    output logic mains_clamp_en,
    output logic core_en,
    // status
    output logic latched
);
    // ************************************************
    // flag synchronisation
    // ************************************************
    sps_sync_if sif();
    assign sif.raw = {over_temperature, mains_above_reset_high, mains_below_reset_low,
                      mains_below_power_down_level, mains_above_start_level,
                      mains_below_stop_level, overvoltage_protect, flyback_timeout_level,
                      flyback_softstart_charged, pfc_softstart_charged,
                      compensation_enable_level, protect_below_trip,
                      protect_above_enable, supply_above_startup,
                      supply_above_lockout, supply_above_trip};
    sps_sync u_sync
    (
        .clk(clk),
        .nrst(nrst),
        .s(sif.sync)
    );
    // synchronised flags
    logic f_trip, f_supply_undervoltage_lockout, f_start, f_pen, f_ptrip, f_comp, f_sspfc, f_ssfly;
    logic f_to, f_ovp, f_mstop, f_mstart, f_pdown, f_flrlo, f_flrhi, f_otp;
    assign f_trip = sif.flag[`SPS_F_TRIP];
    assign f_supply_undervoltage_lockout = sif.flag[`SPS_F_SUPPLY_UNDERVOLTAGE_LOCKOUT];
    assign f_start = sif.flag[`SPS_F_START];
    assign f_pen = sif.flag[`SPS_F_PROT_EN];
    assign f_ptrip = sif.flag[`SPS_F_PROT_TRIP];
    assign f_comp = sif.flag[`SPS_F_COMP_EN];
    assign f_sspfc = sif.flag[`SPS_F_SS_PFC];
    assign f_ssfly = sif.flag[`SPS_F_SS_FLY];
    assign f_to = sif.flag[`SPS_F_FLY_TO];
    assign f_ovp = sif.flag[`SPS_F_OVP];
    assign f_mstop = sif.flag[`SPS_F_MAINS_STOP];
    assign f_mstart = sif.flag[`SPS_F_MAINS_START];
    assign f_pdown = sif.flag[`SPS_F_PDOWN];
    assign f_flrlo = sif.flag[`SPS_F_FLR_LOW];
    assign f_flrhi = sif.flag[`SPS_F_FLR_HIGH];
    assign f_otp = sif.flag[`SPS_F_OTP];

    // state and latches
    sps_pkg::sps_state_t state;
    sps_pkg::sps_state_t next_state;
    logic prot_seen; // protect input reached its enable level
    logic mains_ok; // power-factor mains hysteresis
    logic flr_armed; // fast reset saw the low level
    logic otp_hold; // over-temperature latch
    logic fault_latch; // any latched protection
    logic protect_fail; // protect input failed during start-up

    // protection events in start-up and run
    logic latch_evt;
    assign latch_evt = f_ptrip || f_otp; // R16 R18
    // fast latch reset completes this cycle
    logic flr_done;
    assign flr_done = flr_armed && f_flrhi;

    // ************************************************
    // sequencer state
    // ************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            sps_pkg::SPS_CHARGE:
                if (f_pdown)
                    next_state = sps_pkg::SPS_PDOWN; // R15
                else if (f_start && !fault_latch)
                    next_state = sps_pkg::SPS_STARTUP; // R3 R11
            sps_pkg::SPS_STARTUP:
                if (f_pdown)
                    next_state = sps_pkg::SPS_PDOWN; // R15
                else if (!f_supply_undervoltage_lockout)
                    next_state = sps_pkg::SPS_CHARGE; // R7 R14
                else if (latch_evt && prot_seen)
                    next_state = sps_pkg::SPS_DECAY; // R16
                else if (prot_seen && f_ssfly)
                    next_state = sps_pkg::SPS_RUN; // R6 R17
            sps_pkg::SPS_RUN:
                if (f_pdown)
                    next_state = sps_pkg::SPS_PDOWN; // R15
                else if (!f_supply_undervoltage_lockout)
                    next_state = sps_pkg::SPS_CHARGE; // R14
                else if (latch_evt || f_to)
                    next_state = sps_pkg::SPS_DECAY; // R8 R9
            sps_pkg::SPS_DECAY:
                if (f_pdown)
                    next_state = sps_pkg::SPS_PDOWN; // R15
                else if (!f_supply_undervoltage_lockout)
                    next_state = sps_pkg::SPS_CHARGE; // R9 R10 R11
            sps_pkg::SPS_PDOWN:
                if (!f_pdown)
                    next_state = sps_pkg::SPS_CHARGE; // R15
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= sps_pkg::SPS_CHARGE;
        else
            state <= next_state;
    end

    // protect input has reached its enable level in this start-up
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prot_seen <= 1'b0;
        else if (state != sps_pkg::SPS_STARTUP && state != sps_pkg::SPS_RUN)
            prot_seen <= 1'b0;
        else if (f_pen)
            prot_seen <= 1'b1; // R17
    end

    // start-up fails this cycle: lockout came before the protect input enabled;
    // combinational, so no stale flag carries charge into the next start-up
    assign protect_fail = state == sps_pkg::SPS_STARTUP && !f_supply_undervoltage_lockout && !prot_seen; // R7

    // ************************************************
    // latched protection
    // ************************************************
    // fast reset sequencing: low first, then high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flr_armed <= 1'b0;
        else if (!fault_latch || flr_done)
            flr_armed <= 1'b0;
        else if (f_flrlo)
            flr_armed <= 1'b1; // R20
    end

    // latched protection; set wins over fast reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fault_latch <= 1'b0; // R21
        else if ((state == sps_pkg::SPS_RUN || state == sps_pkg::SPS_STARTUP) && prot_seen && latch_evt)
            fault_latch <= 1'b1; // R10 R16
        else if (f_otp)
            fault_latch <= 1'b1; // R22
        else if (flr_done)
            fault_latch <= 1'b0; // R20
    end

    // over-temperature hold blocks recharge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            otp_hold <= 1'b0;
        else if (f_otp)
            otp_hold <= 1'b1; // R22
        else if (flr_done)
            otp_hold <= 1'b0; // R22
    end

    // mains hysteresis for the power-factor stage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mains_ok <= 1'b0;
        else if (f_mstop)
            mains_ok <= 1'b0; // R13
        else if (f_mstart)
            mains_ok <= 1'b1; // R13
    end

    // ************************************************
    // registered outputs
    // ************************************************
    logic [1:0] next_charge;
    always_comb
    begin
        if (otp_hold || state == sps_pkg::SPS_PDOWN || (state == sps_pkg::SPS_STARTUP && !protect_fail)
            || state == sps_pkg::SPS_RUN || state == sps_pkg::SPS_DECAY)
            next_charge = `SPS_CHG_OFF; // R3 R9 R15 R22
        else if (!f_trip || f_supply_undervoltage_lockout)
            next_charge = `SPS_CHG_LOW; // R1 R2
        else
            next_charge = `SPS_CHG_HIGH; // R1 R10 R11
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            charge_level <= `SPS_CHG_OFF;
            pfc_drive_en <= 1'b0;
            flyback_drive_en <= 1'b0;
            protect_source_en <= 1'b0;
            softstart_en <= 1'b0;
            compensation_clamp_en <= 1'b0;
            mains_clamp_en <= 1'b0;
            core_en <= 1'b0;
            latched <= 1'b0;
        end
        else
        begin
            charge_level <= next_charge;
            // R5 R12 R13
            pfc_drive_en <= next_state == sps_pkg::SPS_RUN && f_pen && f_comp && f_sspfc && !f_ovp && mains_ok;
            flyback_drive_en <= next_state == sps_pkg::SPS_RUN; // R6 R14
            protect_source_en <= next_state == sps_pkg::SPS_STARTUP || next_state == sps_pkg::SPS_RUN; // R4 R7
            softstart_en <= next_state == sps_pkg::SPS_STARTUP || next_state == sps_pkg::SPS_RUN; // R4
            compensation_clamp_en <= next_state == sps_pkg::SPS_STARTUP || next_state == sps_pkg::SPS_RUN; // R4
            mains_clamp_en <= !fault_latch; // R19
            core_en <= next_state == sps_pkg::SPS_STARTUP || next_state == sps_pkg::SPS_RUN; // R3 R15
            latched <= fault_latch;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    AST_PDOWN_OFF: assert property (@(posedge clk) disable iff (!nrst) // R15
        f_pdown |=> ##1 (charge_level == `SPS_CHG_OFF && !flyback_drive_en))
        else $error("power down left drive or charge on");
    AST_NO_RUN_LATCHED: assert property (@(posedge clk) disable iff (!nrst) // R10
        (fault_latch && state == sps_pkg::SPS_CHARGE) |=> state != sps_pkg::SPS_STARTUP)
        else $error("latched part restarted");
    AST_TIMEOUT: assert property (@(posedge clk) disable iff (!nrst) // R8
        (state == sps_pkg::SPS_RUN && f_to && f_supply_undervoltage_lockout && !f_pdown) |=> state == sps_pkg::SPS_DECAY)
        else $error("time-out ignored");
    AST_SUPPLY_UNDERVOLTAGE_LOCKOUT: assert property (@(posedge clk) disable iff (!nrst) // R14
        (state == sps_pkg::SPS_RUN && !f_supply_undervoltage_lockout && !f_pdown) |=> (state == sps_pkg::SPS_CHARGE && !flyback_drive_en))
        else $error("lockout did not stop converters");
    AST_OVP: assert property (@(posedge clk) disable iff (!nrst) // R12
        f_ovp |=> !pfc_drive_en)
        else $error("power-factor ran in overvoltage");
    AST_PFC_ENABLE: assert property (@(posedge clk) disable iff (!nrst) // R5
        pfc_drive_en |-> $past(f_comp) && $past(f_sspfc) && $past(f_pen))
        else $error("power-factor enabled without its flags");
    AST_OTP: assert property (@(posedge clk) disable iff (!nrst) // R22
        f_otp |=> ##1 (charge_level == `SPS_CHG_OFF && latched))
        else $error("over-temperature not latched");
    AST_CLAMP: assert property (@(posedge clk) disable iff (!nrst) // R19
        fault_latch |=> !mains_clamp_en)
        else $error("mains clamp on while latched");
    AST_HIGH_CHARGE: assert property (@(posedge clk) disable iff (!nrst) // R1
        (state == sps_pkg::SPS_CHARGE && !otp_hold && !f_trip) |=> charge_level == `SPS_CHG_LOW)
        else $error("high charge below trip");
    AST_STARTUP_ENABLES: assert property (@(posedge clk) disable iff (!nrst) // R4
        (state == sps_pkg::SPS_CHARGE && f_start && !fault_latch && !f_pdown)
        |=> (protect_source_en && softstart_en && compensation_clamp_en && core_en))
        else $error("start-up enables missing");
    AST_STARTUP_CHARGE_OFF: assert property (@(posedge clk) disable iff (!nrst) // R3
        (state == sps_pkg::SPS_STARTUP && f_supply_undervoltage_lockout) |=> charge_level == `SPS_CHG_OFF)
        else $error("charge left on during start-up");
    AST_STARTUP_FAIL: assert property (@(posedge clk) disable iff (!nrst) // R7
        (state == sps_pkg::SPS_STARTUP && !f_supply_undervoltage_lockout && !prot_seen && !f_pdown && !otp_hold)
        |=> (!protect_source_en && charge_level != `SPS_CHG_OFF))
        else $error("failed start-up did not recharge");
    AST_FLYBACK_SOFTSTART: assert property (@(posedge clk) disable iff (!nrst) // R6
        (state == sps_pkg::SPS_STARTUP && !f_ssfly) |=> !flyback_drive_en)
        else $error("flyback enabled before its soft-start");
    AST_MAINS_STOP: assert property (@(posedge clk) disable iff (!nrst) // R13
        f_mstop |=> ##1 !pfc_drive_en)
        else $error("power-factor ran below mains stop level");
    AST_PROTECT_TRIP: assert property (@(posedge clk) disable iff (!nrst) // R16
        (state == sps_pkg::SPS_RUN && prot_seen && f_ptrip)
        |=> (fault_latch && !flyback_drive_en && !pfc_drive_en))
        else $error("protect trip did not latch both off");
endmodule // sps_top
`default_nettype wire

// [testbench/sps_supply_model.sv]
// supply capacitor model: charged by the start-up source, held by the aux winding
// assumes charge codes from sps_map.svh and one shared clock
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module sps_supply_model
#(
    parameter int TRIP = 20,
    parameter int LOCK = 60,
    parameter int START = 100
)
(
    // clock and supply removal
    input wire logic clk,
    input wire logic nrst,
    // controls from the sequencer
    input wire logic [1:0] charge_level,
    input wire logic flyback_drive_en,
    // aux winding lost: supply decays even while the flyback runs
    input wire logic aux_lost,
    // supply comparators
    output logic above_trip,
    output logic above_lockout,
    output logic above_startup
);
    int vcc; // supply level in model units
    // low source adds 1 up to 120, high adds 2, else the supply decays
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            vcc <= 0;
        else if (flyback_drive_en && !aux_lost)
            vcc <= vcc; // aux winding takes over
        else if (charge_level == `SPS_CHG_HIGH)
            vcc <= vcc + 2;
        else if (charge_level == `SPS_CHG_LOW)
            vcc <= (vcc < 120) ? vcc + 1 : vcc;
        else if (vcc > 0)
            vcc <= vcc - 1;
    end
    assign above_trip = (vcc >= TRIP);
    assign above_lockout = (vcc >= LOCK);
    assign above_startup = (vcc >= START);
endmodule // sps_supply_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the start-up and protection sequencer
// assumes the supply model closes the loop on the supply comparators
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module tb;
    // ****************************************
    // signals
    // ****************************************
    logic clk = 0;
    logic nrst = 0;
    logic supply_above_trip, supply_above_lockout, supply_above_startup;
    logic protect_above_enable = 0, protect_below_trip = 0;
    logic compensation_enable_level = 0, pfc_softstart_charged = 0;
    logic flyback_softstart_charged = 1, flyback_timeout_level = 0;
    logic overvoltage_protect = 0, mains_below_stop_level = 0;
    logic mains_above_start_level = 0, mains_below_power_down_level = 0;
    logic mains_below_reset_low = 0, mains_above_reset_high = 1;
    logic over_temperature = 0;
    logic aux_lost = 0; // supply model: aux winding fails
    logic [1:0] charge_level;
    logic pfc_drive_en, flyback_drive_en, protect_source_en, softstart_en;
    logic compensation_clamp_en, mains_clamp_en, core_en, latched;
    int error_cnt = 0;
    int n_tests = 0;
    // ****************************************
    // design and supply model
    // ****************************************
    sps_top uut (.clk, .nrst, .supply_above_trip, .supply_above_lockout, .supply_above_startup,
        .protect_above_enable, .protect_below_trip, .compensation_enable_level,
        .pfc_softstart_charged, .flyback_softstart_charged, .flyback_timeout_level,
        .overvoltage_protect, .mains_below_stop_level, .mains_above_start_level,
        .mains_below_power_down_level, .mains_below_reset_low, .mains_above_reset_high,
        .over_temperature, .charge_level, .pfc_drive_en, .flyback_drive_en, .protect_source_en,
        .softstart_en, .compensation_clamp_en, .mains_clamp_en, .core_en, .latched);
    sps_supply_model model (.clk, .nrst, .charge_level, .flyback_drive_en, .aux_lost,
        .above_trip(supply_above_trip), .above_lockout(supply_above_lockout),
        .above_startup(supply_above_startup));
    // 100 MHz clock
    always #5 clk = ~clk;
    // ****************************************
    // helpers
    // ****************************************
    // selects an observed level by index
    function automatic logic pick(input int k);
        case (k)
            0: pick = core_en;
            1: pick = flyback_drive_en;
            2: pick = pfc_drive_en;
            3: pick = latched;
            4: pick = (charge_level != `SPS_CHG_OFF);
            5: pick = protect_source_en;
            6: pick = supply_above_trip;
            default: pick = supply_above_lockout;
        endcase
    endfunction
    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // waits a bounded time for a level, then compares it
    task automatic wait_until(input int k, input logic v, input int lim, input string what);
        int i;
        i = 0;
        while (i < lim && pick(k) !== v)
        begin
            step(1);
            i++;
        end
        chk(what, {1'b0, v}, {1'b0, pick(k)});
    endtask
    // a level must stay low for n cycles
    task automatic hold_low(input int k, input int n, input string what);
        logic seen;
        seen = 0;
        repeat (n)
        begin
            step(1);
            seen = seen | (pick(k) !== 1'b0);
        end
        chk(what, 2'h0, {1'b0, seen});
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // charging phases, then a start-up whose protect input never enables
    task automatic t_startup();
        step(6);
        chk("charge below trip", `SPS_CHG_LOW, charge_level);
        wait_until(6, 1, 100, "trip seen");
        step(6);
        chk("charge above trip", `SPS_CHG_HIGH, charge_level);
        wait_until(7, 1, 100, "lockout seen");
        step(6);
        chk("charge above lockout", `SPS_CHG_LOW, charge_level);
        wait_until(0, 1, 100, "core on");
        chk("protect source", 2'h1, {1'b0, protect_source_en});
        chk("softstart", 2'h1, {1'b0, softstart_en});
        chk("comp clamp", 2'h1, {1'b0, compensation_clamp_en});
        step(2);
        chk("charge after start", `SPS_CHG_OFF, charge_level);
        hold_low(1, 20, "flyback inhibited");
        wait_until(5, 0, 100, "source off late");
        wait_until(4, 1, 10, "recharge late");
        $display("test startup done");
    endtask
    // full enable chain of both converters
    task automatic t_run();
        @(posedge clk);
        protect_above_enable <= 1;
        flyback_softstart_charged <= 0;
        wait_until(0, 1, 100, "core on again");
        hold_low(1, 20, "flyback waits softstart");
        @(posedge clk);
        flyback_softstart_charged <= 1;
        wait_until(1, 1, 200, "flyback on");
        chk("pfc waits", 2'h0, {1'b0, pfc_drive_en});
        @(posedge clk);
        compensation_enable_level <= 1;
        pfc_softstart_charged <= 1;
        mains_above_start_level <= 1;
        wait_until(2, 1, 10, "pfc on");
        $display("test run done");
    endtask
    // overvoltage and mains undervoltage stop only the power-factor stage
    task automatic t_pfc_only();
        @(posedge clk);
        overvoltage_protect <= 1;
        wait_until(2, 0, 8, "pfc off ovp");
        chk("flyback kept", 2'h1, {1'b0, flyback_drive_en});
        @(posedge clk);
        overvoltage_protect <= 0;
        wait_until(2, 1, 8, "pfc back");
        @(posedge clk);
        mains_below_stop_level <= 1;
        mains_above_start_level <= 0;
        wait_until(2, 0, 8, "pfc off mains");
        @(posedge clk);
        mains_below_stop_level <= 0;
        hold_low(2, 10, "pfc hysteresis");
        @(posedge clk);
        mains_above_start_level <= 1;
        wait_until(2, 1, 8, "pfc resume");
        $display("test pfc only done");
    endtask
    // control time-out: stop, decay, recharge and start again
    task automatic t_restart();
        @(posedge clk);
        flyback_timeout_level <= 1;
        wait_until(1, 0, 8, "flyback off to");
        chk("pfc off to", 2'h0, {1'b0, pfc_drive_en});
        @(posedge clk);
        flyback_timeout_level <= 0;
        wait_until(4, 1, 100, "recharge");
        chk("not latched", 2'h0, {1'b0, latched});
        wait_until(1, 1, 300, "restart");
        @(posedge clk);
        aux_lost <= 1;
        wait_until(1, 0, 100, "lockout stop");
        wait_until(4, 1, 10, "lockout recharge");
        @(posedge clk);
        aux_lost <= 0;
        wait_until(1, 1, 300, "lockout restart");
        $display("test restart done");
    endtask
    // one-cycle protect trip latches; fast reset needs low then high
    task automatic t_latch();
        @(posedge clk);
        protect_below_trip <= 1;
        @(posedge clk);
        protect_below_trip <= 0;
        wait_until(3, 1, 8, "latched");
        chk("both off", 2'h0, {pfc_drive_en, flyback_drive_en});
        chk("mains clamp off", 2'h0, {1'b0, mains_clamp_en});
        wait_until(4, 1, 100, "latched recharge");
        hold_low(1, 200, "no restart");
        @(posedge clk);
        mains_above_reset_high <= 0;
        repeat (3) @(posedge clk);
        mains_above_reset_high <= 1;
        step(8);
        chk("high alone", 2'h1, {1'b0, latched});
        @(posedge clk);
        mains_above_reset_high <= 0;
        mains_below_reset_low <= 1;
        repeat (6) @(posedge clk);
        mains_below_reset_low <= 0;
        repeat (3) @(posedge clk);
        mains_above_reset_high <= 1;
        wait_until(3, 0, 8, "fast reset");
        wait_until(1, 1, 300, "after reset");
        $display("test latch done");
    endtask
    // over-temperature latches without recharge; supply removal clears it
    task automatic t_otp();
        @(posedge clk);
        over_temperature <= 1;
        wait_until(3, 1, 8, "otp latched");
        hold_low(4, 150, "otp no charge");
        @(posedge clk);
        over_temperature <= 0;
        nrst <= 0;
        repeat (3) @(posedge clk);
        nrst <= 1;
        step(2);
        chk("por clear", 2'h0, {1'b0, latched});
        wait_until(1, 1, 400, "por restart");
        $display("test otp done");
    endtask
    // power down stops all, no recharge until mains returns
    task automatic t_pdown();
        @(posedge clk);
        mains_below_power_down_level <= 1;
        wait_until(1, 0, 8, "pd off");
        wait_until(0, 0, 8, "pd core off");
        hold_low(4, 150, "pd no charge");
        @(posedge clk);
        mains_below_power_down_level <= 0;
        wait_until(1, 1, 400, "pd restart");
        $display("test power down done");
    endtask
    // ****************************************
    // sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        t_startup();
        t_run();
        t_pfc_only();
        t_restart();
        t_latch();
        t_otp();
        t_pdown();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule // tb
`default_nettype wire
